// *** hdl/lamp_pwm_pkg.sv ***
// Constants and types shared by the lamp dimming PWM block
package lamp_pwm_pkg;
  localparam int          CHANNELS        = 6;
  localparam int          INTERNAL_CHANS  = 5;
  localparam int          INPUT_CHANS     = 4;
  localparam int          DEGLITCH_CYCLES = 16;
  localparam int          WORD_WIDTH      = 11;
  localparam int          WORD_ON_BIT     = 8;
  localparam int          WORD_PHASE_LSB  = 9;
  localparam logic [7:0]  DUTY_RESET      = 8'h00;
  localparam logic [7:0]  DUTY_FULL       = 8'hff;
  localparam logic [7:0]  DUTY_INTERP_LOW = 8'hf7;
  localparam logic [7:0]  DUTY_MIN        = 8'h00;
  localparam logic [7:0]  PERIOD_LAST     = 8'hff;
  localparam logic [7:0]  STEP_4          = 8'h04;
  localparam logic [7:0]  STEP_8          = 8'h08;
  localparam logic [7:0]  STEP_16         = 8'h10;
  localparam logic [1:0]  DIV4_LAST       = 2'h3;
  localparam logic [1:0]  DIV2_LAST       = 2'h1;
  localparam logic [1:0]  DIV1_LAST       = 2'h0;
  localparam logic [1:0]  PHASE_RESET     = 2'h0;
  localparam logic [5:0]  PHASE_PAD       = 6'h00;

  typedef enum logic [1:0]
  {
    DIV_BY_4 = 2'b00,
    DIV_BY_2 = 2'b01,
    DIV_BY_1 = 2'b10,
    DIV_BY_1_ALT = 2'b11
  } divider_type;

  typedef enum logic [1:0]
  {
    GATE_NONE = 2'b00,
    GATE_LO   = 2'b01,
    GATE_HI   = 2'b10,
    GATE_SWAP = 2'b11
  } gating_mode_type;
endpackage

// *** hdl/input_deglitch.sv ***
// Two-stage synchroniser and stability filter for one control pin
`timescale 1ns/1ps
module input_deglitch
#(
  parameter int STABLE_CYCLES = 16
)
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      filtered_o
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] COUNT_LAST = CW'(STABLE_CYCLES - 1);

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] count;

  generate
    if (STABLE_CYCLES < 1)
    begin : g_bad
      $error("STABLE_CYCLES must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= pin_i;
      sync_b <= sync_a;
    end
  end

  // Accept a new level only after it held steady
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count      <= '0;
      filtered_o <= 1'b0;
    end
    else if (sync_b == filtered_o)
      count <= '0;
    else if (count == COUNT_LAST)
    begin
      count      <= '0;
      filtered_o <= sync_b;
    end
    else
      count <= count + CW'(1);
  end
endmodule

// *** hdl/pwm_channel.sv ***
// One PWM channel: prescaler, phased period counter, duty shadow, interpolation
`timescale 1ns/1ps
module pwm_channel
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       ref_tick_i,
  input  wire logic       counter_reset_i,
  input  wire logic       drive_i,
  input  wire logic [7:0] duty_i,
  input  wire logic       interp_enable_i,
  input  wire logic [1:0] divider_select_i,
  input  wire logic [1:0] phase_i,
  output logic            pwm_o
);
  import lamp_pwm_pkg::*;

  logic [1:0] div_cnt;
  logic [1:0] div_last;
  logic       step;
  logic [7:0] cnt;
  logic [7:0] phased;
  logic       period_start;
  logic [7:0] shadow;
  logic       started;
  logic [2:0] frame;
  logic [7:0] low_slots;
  logic [7:0] eff_duty;

  always_comb
  begin
    case (divider_select_i)
      DIV_BY_4: div_last = DIV4_LAST;
      DIV_BY_2: div_last = DIV2_LAST;
      default:  div_last = DIV1_LAST;
    endcase
  end

  assign step         = ref_tick_i && (div_cnt >= div_last);
  assign phased       = cnt + {phase_i, PHASE_PAD};
  assign period_start = step && (phased == PERIOD_LAST);
  assign low_slots    = DUTY_FULL - shadow;

  always_ff @(posedge clk_i)
  begin
    if (reset_i || counter_reset_i)
      div_cnt <= 2'h0;
    else if (step)
      div_cnt <= 2'h0;
    else if (ref_tick_i)
      div_cnt <= div_cnt + 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || counter_reset_i)
      cnt <= 8'h00;
    else if (step)
      cnt <= cnt + 8'h01;
  end

  // Full duty starts at once, lower duty waits for the next period
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !drive_i)
      started <= 1'b0;
    else if (duty_i == DUTY_FULL || period_start)
      started <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      shadow <= DUTY_RESET;
    else if (duty_i == DUTY_FULL || period_start || !started)
      shadow <= duty_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || counter_reset_i)
      frame <= 3'h0;
    else if (period_start)
      frame <= frame + 3'h1;
  end

  // Slots take the low code in bit-reversed order of the frame index
  always_comb
  begin
    eff_duty = shadow;
    if (interp_enable_i && shadow > DUTY_INTERP_LOW && shadow != DUTY_FULL)
    begin
      if ({5'h00, frame[0], frame[1], frame[2]} < low_slots)
        eff_duty = DUTY_INTERP_LOW;
      else
        eff_duty = DUTY_FULL;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pwm_o <= 1'b0;
    else
      pwm_o <= drive_i && started && (eff_duty == DUTY_FULL || phased <= eff_duty);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_idle_dark:      assert property (!drive_i |=> !pwm_o)
    else $error("output on while channel drive is off");
  a_full_now:       assert property ((drive_i && duty_i == DUTY_FULL) ##1 (drive_i && duty_i == DUTY_FULL) |=> pwm_o)
    else $error("full duty not applied at once");
  a_start_waits:    assert property ($rose(drive_i) && duty_i != DUTY_FULL && !period_start |=> !started)
    else $error("partial duty started before period start");
  a_sync_clears:    assert property (counter_reset_i |=> cnt == 8'h00 && frame == 3'h0)
    else $error("counter not cleared by phase sync");
  c_interp_low:     cover property (interp_enable_i && started && eff_duty == DUTY_INTERP_LOW && shadow != eff_duty);
endmodule

// *** hdl/lamp_pwm.sv ***
// Multichannel lamp dimming PWM: duty registers, gating logic and mode selection
//
// Behaviour
// - Partial duty applies at next period start
// - Phase sync write resets all PWM counters
// - Divider code selects divide by 4, 2, 1
// - Eight-period pattern interpolates codes F8 to FE
// - No modulation in Fail or clock failure
// - Shared select picks own or global duty
// - Global duty comes from global duty input
// - On bit, gating mode, input combine per table
// - Global channels keep own phase, divider, interpolation
// - Increment write steps five internal channels only
// - Direction bit zero subtracts, one adds
// - Step size codes give 0, 4, 8, 16
// - Stepping saturates at 00 and FF
// - Interpolation enable per internal channel, not external
// - Fail mode: inputs drive 1-4, 5-6 off
// - Normal: 5-6 on bits; rise starts window
// - Control inputs pass a deglitch filter
// - Full duty, off, phase, divider act immediately
// - Channel word carries phase, on, duty
// - Failed reference clock gives full duty
`timescale 1ns/1ps
module lamp_pwm
#(
  parameter int DEGLITCH_CYCLES = lamp_pwm_pkg::DEGLITCH_CYCLES
)
(
  input  wire logic                                            clk_i,
  input  wire logic                                            reset_i,
  input  wire logic                                            ref_clk_i,
  input  wire logic                                            ref_clock_failed_i,
  input  wire logic                                            fail_mode_i,
  input  wire logic [lamp_pwm_pkg::CHANNELS-1:0]               chan_wr_i,
  input  wire logic [lamp_pwm_pkg::WORD_WIDTH-1:0]             chan_data_i,
  input  wire logic                                            init2_wr_i,
  input  wire logic                                            counter_phase_sync_i,
  input  wire logic [lamp_pwm_pkg::CHANNELS-1:0]               shared_duty_select_i,
  input  wire logic [7:0]                                      global_duty_i,
  input  wire logic [2*lamp_pwm_pkg::CHANNELS-1:0]             clock_divider_select_i,
  input  wire logic [lamp_pwm_pkg::INTERNAL_CHANS-1:0]         frame_interpolation_enable_i,
  input  wire logic [2*lamp_pwm_pkg::INPUT_CHANS-1:0]          input_gating_mode_i,
  input  wire logic                                            inc_wr_i,
  input  wire logic                                            step_direction_i,
  input  wire logic [2*lamp_pwm_pkg::INTERNAL_CHANS-1:0]       step_size_i,
  input  wire logic [lamp_pwm_pkg::INPUT_CHANS-1:0]            direct_control_input_i,
  input  wire logic [lamp_pwm_pkg::INPUT_CHANS-1:0]            fail_window_control_i,
  output logic      [lamp_pwm_pkg::CHANNELS-1:0]               channel_drive_o,
  output logic      [lamp_pwm_pkg::CHANNELS-1:0]               lamp_out_o,
  output logic      [lamp_pwm_pkg::INTERNAL_CHANS-1:0]         window_start_o
);
  import lamp_pwm_pkg::*;

  logic [7:0]                own_duty [CHANNELS];
  logic [1:0]                phase    [CHANNELS];
  logic [CHANNELS-1:0]       ch_on;
  logic [CHANNELS-1:0]       drive;
  logic [CHANNELS-1:0]       pwm;
  logic [CHANNELS-1:0]       drive_prev;
  logic [INPUT_CHANS-1:0]    filtered_input;
  logic [INPUT_CHANS-1:0]    fwc_prev;
  logic                      ref_sync_a;
  logic                      ref_sync_b;
  logic                      ref_sync_c;
  logic                      ref_tick;
  logic                      counter_reset;

  generate
    if (DEGLITCH_CYCLES < 1)
    begin : g_bad
      $error("DEGLITCH_CYCLES must be at least 1");
    end
  endgenerate

  // Saturating step of one duty value
  function automatic logic [7:0] step_duty(input logic [7:0] duty, input logic [1:0] size, input logic up);
    logic [7:0] amount;
    logic [8:0] sum;
    amount = 8'h00;
    sum    = 9'h000;
    case (size)
      2'b01:   amount = STEP_4;
      2'b10:   amount = STEP_8;
      2'b11:   amount = STEP_16;
      default: amount = 8'h00;
    endcase
    if (up)
    begin
      sum = {1'b0, duty} + {1'b0, amount};
      step_duty = sum[8] ? DUTY_FULL : sum[7:0];
    end
    else
      step_duty = (duty < amount) ? DUTY_MIN : duty - amount;
  endfunction

  // Reference clock pin sampled into this domain
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ref_sync_a <= 1'b0;
      ref_sync_b <= 1'b0;
      ref_sync_c <= 1'b0;
    end
    else
    begin
      ref_sync_a <= ref_clk_i;
      ref_sync_b <= ref_sync_a;
      ref_sync_c <= ref_sync_b;
    end
  end

  assign ref_tick      = ref_sync_b && !ref_sync_c;
  assign counter_reset = init2_wr_i && counter_phase_sync_i;

  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++)
    begin : g_chan
      logic [7:0] sel_duty;
      logic       use_global;
      logic       interp_en;

      always_ff @(posedge clk_i)
      begin
        if (reset_i)
        begin
          own_duty[i] <= DUTY_RESET;
          ch_on[i]    <= 1'b0;
          phase[i]    <= PHASE_RESET;
        end
        else if (chan_wr_i[i])
        begin
          phase[i]    <= chan_data_i[WORD_PHASE_LSB +: 2];
          ch_on[i]    <= chan_data_i[WORD_ON_BIT];
          own_duty[i] <= chan_data_i[7:0];
        end
        else if (inc_wr_i && i < INTERNAL_CHANS)
          own_duty[i] <= step_duty(own_duty[i], step_size_i[2*(i%INTERNAL_CHANS) +: 2], step_direction_i);
      end

      if (i < INPUT_CHANS)
      begin : g_input
        gating_mode_type mode;

        input_deglitch
        #(
          .STABLE_CYCLES (DEGLITCH_CYCLES)
        )
        u_deglitch
        (
          .clk_i      (clk_i),
          .reset_i    (reset_i),
          .pin_i      (direct_control_input_i[i]),
          .filtered_o (filtered_input[i])
        );

        assign mode = gating_mode_type'(input_gating_mode_i[2*i +: 2]);

        always_comb
        begin
          use_global = shared_duty_select_i[i];
          if (fail_mode_i)
            drive[i] = filtered_input[i];
          else if (!ch_on[i])
            drive[i] = 1'b0;
          else
          begin
            case (mode)
              GATE_NONE: drive[i] = 1'b1;
              GATE_LO:   drive[i] = filtered_input[i];
              GATE_HI:   drive[i] = filtered_input[i];
              GATE_SWAP:
              begin
                drive[i]   = 1'b1;
                use_global = shared_duty_select_i[i] ^ filtered_input[i];
              end
              default:   drive[i] = 1'b0;
            endcase
          end
        end
      end
      else
      begin : g_plain
        always_comb
        begin
          use_global = shared_duty_select_i[i];
          drive[i]   = ch_on[i] && !fail_mode_i;
        end
      end

      assign sel_duty  = use_global ? global_duty_i : own_duty[i];
      assign interp_en = (i < INTERNAL_CHANS) ? frame_interpolation_enable_i[i % INTERNAL_CHANS] : 1'b0;

      pwm_channel u_channel
      (
        .clk_i            (clk_i),
        .reset_i          (reset_i),
        .ref_tick_i       (ref_tick),
        .counter_reset_i  (counter_reset),
        .drive_i          (drive[i]),
        .duty_i           (sel_duty),
        .interp_enable_i  (interp_en),
        .divider_select_i (clock_divider_select_i[2*i +: 2]),
        .phase_i          (phase[i]),
        .pwm_o            (pwm[i])
      );

      // Output selection by operating mode
      always_ff @(posedge clk_i)
      begin
        if (reset_i)
          lamp_out_o[i] <= 1'b0;
        else if (fail_mode_i)
          lamp_out_o[i] <= drive[i];
        else if (ref_clock_failed_i)
          lamp_out_o[i] <= drive[i];
        else
          lamp_out_o[i] <= pwm[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      drive_prev      <= '0;
      channel_drive_o <= '0;
      fwc_prev        <= '0;
    end
    else
    begin
      drive_prev      <= drive;
      channel_drive_o <= drive;
      fwc_prev        <= fail_window_control_i;
    end
  end

  // Overcurrent window starts
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      window_start_o <= '0;
    else if (fail_mode_i)
      window_start_o <= {1'b0, fail_window_control_i & ~fwc_prev};
    else
      window_start_o <= drive[INTERNAL_CHANS-1:0] & ~drive_prev[INTERNAL_CHANS-1:0];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_fail_high_off:   assert property (fail_mode_i |=> !lamp_out_o[4] && !lamp_out_o[5])
    else $error("channels five and six on in fail mode");
  a_fail_follow_in:  assert property (fail_mode_i |=> lamp_out_o[3:0] == $past(filtered_input))
    else $error("fail mode output does not follow filtered inputs");
  a_clkfail_full:    assert property (!fail_mode_i && ref_clock_failed_i |=> lamp_out_o == $past(drive))
    else $error("failed reference clock output not at full duty");
  a_off_dark:        assert property (!ch_on[0] && !fail_mode_i ##1 !ch_on[0] && !fail_mode_i
                                      |=> !lamp_out_o[0])
    else $error("channel on while its on bit is clear");
  a_incr_sat_up:     assert property (inc_wr_i && !chan_wr_i[0] && step_direction_i && step_size_i[1:0] == 2'b11
                                      && own_duty[0] > 8'hef |=> own_duty[0] == DUTY_FULL)
    else $error("increment did not saturate at full");
  a_incr_down_four:  assert property (inc_wr_i && !chan_wr_i[0] && !step_direction_i && step_size_i[1:0] == 2'b01
                                      && own_duty[0] >= STEP_4 |=> own_duty[0] == $past(own_duty[0]) - STEP_4)
    else $error("decrement by four wrong");
  a_ext_unstepped:   assert property (inc_wr_i && !chan_wr_i[5] |=> own_duty[5] == $past(own_duty[5]))
    else $error("external channel duty changed by increment");
  a_window_rise:     assert property (!fail_mode_i && drive[4] && !drive_prev[4] |=> window_start_o[4])
    else $error("window not started on drive rise");
  a_fail_window:     assert property (fail_mode_i && fail_window_control_i[0] && !fwc_prev[0] |=> window_start_o[0])
    else $error("fail window input rise not passed on");
  a_chan_load:       assert property (chan_wr_i[0] |=> own_duty[0] == $past(chan_data_i[7:0])
                                      && ch_on[0] == $past(chan_data_i[WORD_ON_BIT]))
    else $error("channel word not loaded");
  a_incr_none:       assert property (inc_wr_i && !chan_wr_i[1] && step_size_i[3:2] == 2'b00
                                      |=> own_duty[1] == $past(own_duty[1]))
    else $error("zero step size changed duty");
  a_incr_sat_down:   assert property (inc_wr_i && !chan_wr_i[1] && !step_direction_i
                                      && step_size_i[3:2] == 2'b11 && own_duty[1] < STEP_16
                                      |=> own_duty[1] == DUTY_MIN)
    else $error("decrement did not saturate at zero");
  a_incr_up_eight:   assert property (inc_wr_i && !chan_wr_i[3] && step_direction_i
                                      && step_size_i[7:6] == 2'b10 && own_duty[3] < 8'hf8
                                      |=> own_duty[3] == $past(own_duty[3]) + STEP_8)
    else $error("increment by eight wrong");
  a_fail_ext_window: assert property (fail_mode_i |=> !window_start_o[4])
    else $error("channel five window started in fail mode");
  a_window_quiet:    assert property (!fail_mode_i && !(drive[0] && !drive_prev[0]) |=> !window_start_o[0])
    else $error("window started without drive rise");
  a_ext_on_bit:      assert property (!fail_mode_i |-> drive[5] == ch_on[5])
    else $error("external channel drive differs from on bit");
  a_gate_blocks:     assert property (!fail_mode_i && ch_on[1] && input_gating_mode_i[3:2] == 2'b01
                                      && !filtered_input[1] |-> !drive[1])
    else $error("gated channel driven while input low");

  c_fail_mode:       cover property (!fail_mode_i ##1 fail_mode_i ##1 lamp_out_o[0]);
  c_incr_write:      cover property (inc_wr_i && step_direction_i && step_size_i != '0);
  c_phase_sync:      cover property (counter_reset ##1 ref_tick);
  c_pwm_toggle:      cover property (lamp_out_o[0] ##1 !lamp_out_o[0] && ch_on[0]);
endmodule

// *** tb/lamp_mcu_model.sv ***
// Controller side model: free-running reference clock and direct control pins
`timescale 1ns/1ps
module lamp_mcu_model
#(
  parameter int REF_HALF = 2
)
(
  input  wire logic       clk_i,
  output logic            ref_clk_o,
  output logic [3:0]      pin_o
);
  logic [3:0] pin_level;
  int         half_cnt;

  initial
  begin
    ref_clk_o = 1'b0;
    pin_o     = 4'h0;
    pin_level = 4'h0;
    half_cnt  = 0;
  end

  // Reference clock toggles every REF_HALF system clocks; pins follow the set level
  always @(posedge clk_i)
  begin
    #1;
    half_cnt = half_cnt + 1;
    if (half_cnt == REF_HALF)
    begin
      half_cnt  = 0;
      ref_clk_o = ~ref_clk_o;
    end
    pin_o = pin_level;
  end

  // One-cycle spike on a pin, restored at the next edge
  task automatic glitch(input int idx);
    @(posedge clk_i);
    #2;
    pin_o[idx] = ~pin_level[idx];
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the lamp dimming PWM block
`timescale 1ns/1ps
module tb_top;
  import lamp_pwm_pkg::*;
  localparam logic [7:0] IDUTY [6] = '{8'hfe, 8'hfb, 8'hf8, 8'hfc, 8'h05, 8'hfd};
  localparam logic [7:0] SDUTY [6] = '{8'hfd, 8'h02, 8'h80, 8'h80, 8'h80, 8'h40};
  logic        clk_i;
  logic        reset_i;
  logic        ref_clk;
  logic        clk_fail;
  logic        fail_mode;
  logic [5:0]  chan_wr;
  logic [10:0] chan_data;
  logic        init2_wr;
  logic        sync_bit;
  logic [5:0]  shared_sel;
  logic [7:0]  gdu;
  logic [11:0] div_sel;
  logic [4:0]  interp;
  logic [7:0]  gating;
  logic        inc_wr;
  logic        step_dir;
  logic [9:0]  step_size;
  logic [3:0]  pins;
  logic [3:0]  fail_win;
  logic [5:0]  drive;
  logic [5:0]  lamp;
  logic [4:0]  win;
  logic [16:0] lfsr;
  logic [5:0]  mon;
  int          errors;
  int          checks;
  int          n;
  int          md[6];
  int          hi[6];
  int          rise[6];

  lamp_mcu_model mcu (.clk_i(clk_i), .ref_clk_o(ref_clk), .pin_o(pins));

  lamp_pwm #(.DEGLITCH_CYCLES(2)) uut (.clk_i(clk_i), .reset_i(reset_i), .ref_clk_i(ref_clk),
    .ref_clock_failed_i(clk_fail), .fail_mode_i(fail_mode), .chan_wr_i(chan_wr), .chan_data_i(chan_data),
    .init2_wr_i(init2_wr), .counter_phase_sync_i(sync_bit), .shared_duty_select_i(shared_sel),
    .global_duty_i(gdu), .clock_divider_select_i(div_sel), .frame_interpolation_enable_i(interp),
    .input_gating_mode_i(gating), .inc_wr_i(inc_wr), .step_direction_i(step_dir), .step_size_i(step_size),
    .direct_control_input_i(pins), .fail_window_control_i(fail_win), .channel_drive_o(drive),
    .lamp_out_o(lamp), .window_start_o(win));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (80000) @(posedge clk_i);
    errors++;
    $display("watchdog expired");
    finish_test();
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %0d seen %0d", name, exp, seen);
    end
  endtask

  function automatic logic [7:0] rnd();
    for (int i = 0; i < 8; i++)
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction

  task automatic tick(input int cnt);
    repeat (cnt) @(posedge clk_i);
    #1;
  endtask

  task automatic wr_chan(input int c, input logic [7:0] ph, input logic on, input logic [7:0] d);
    tick(1);
    chan_data = {ph[1:0], on, d};
    chan_wr[c] = 1'b1;
    tick(1);
    chan_wr = 6'h00;
    md[c] = d;
    mon[c] = on;
  endtask

  task automatic inc_write(input logic dir, input logic [9:0] sz);
    int st;
    tick(1);
    step_dir = dir;
    step_size = sz;
    inc_wr = 1'b1;
    tick(1);
    inc_wr = 1'b0;
    for (int c = 0; c < 5; c++)
    begin
      st = (sz[2*c+:2] == 2'b00) ? 0 : (2 << sz[2*c+:2]);
      md[c] = dir ? ((md[c] + st > 255) ? 255 : md[c] + st) : ((md[c] < st) ? 0 : md[c] - st);
    end
  endtask

  function automatic int dv(int c);
    return div_sel[2*c+1] ? 1 : (div_sel[2*c] ? 2 : 4);
  endfunction

  function automatic logic on_exp(int c);
    if (!mon[c])
      return 1'b0;
    if (c < 4 && gating[2*c+:2] inside {2'b01, 2'b10})
      return mcu.pin_level[c];
    return 1'b1;
  endfunction

  function automatic int eff(int c);
    logic s;
    s = shared_sel[c] ^ (c < 4 && gating[2*c+:2] == 2'b11 && mcu.pin_level[c]);
    return s ? int'(gdu) : md[c];
  endfunction

  function automatic int exp_hi(int c, int cyc, logic ip);
    int d;
    d = eff(c);
    if (!on_exp(c))
      return 0;
    if (ip && c < 5 && d >= 248 && d < 255)
      return ((255 - d) * 248 + (8 - 255 + d) * 256) * cyc / 2048;
    return (d + 1) * cyc / 256;
  endfunction

  // Settle, then count high cycles and rising edges of every lamp output
  task automatic check_all(input int cyc, input logic [5:0] ip);
    logic [5:0] prev;
    tick(cyc + 20);
    hi = '{default: 0};
    rise = '{default: 0};
    prev = lamp;
    repeat (cyc)
    begin
      tick(1);
      for (int c = 0; c < 6; c++)
      begin
        hi[c] += int'(lamp[c]);
        rise[c] += int'(lamp[c] & ~prev[c]);
      end
      prev = lamp;
    end
    for (int c = 0; c < 6; c++)
    begin
      check("on time", hi[c], exp_hi(c, cyc, ip[c]));
      if (on_exp(c) && eff(c) < 255 && !(ip[c] && eff(c) >= 248))
        check("period count", rise[c], cyc / (1024 * dv(c)));
    end
  endtask

  task automatic wait_win(input int b);
    n = 0;
    while (win[b] !== 1'b1 && n < 6)
    begin
      tick(1);
      n++;
    end
  endtask

  initial
  begin
    reset_i = 1'b1;
    clk_fail = 1'b0;
    fail_mode = 1'b0;
    chan_wr = 6'h00;
    chan_data = 11'h000;
    init2_wr = 1'b0;
    sync_bit = 1'b0;
    shared_sel = 6'h00;
    gdu = 8'h00;
    div_sel = 12'haaa;
    interp = 5'h00;
    gating = 8'h00;
    inc_wr = 1'b0;
    step_dir = 1'b0;
    step_size = 10'h000;
    fail_win = 4'h0;
    lfsr = 17'h10e97;
    mon = 6'h00;
    md = '{default: 0};
    repeat (20) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    tick(4);
    check("drive", drive, 6'h00);
    check("lamp", lamp, 6'h00);
    $display("test reset finished");
    for (int c = 0; c < 6; c++)
      wr_chan((c + 5) % 6, rnd(), 1'b1, rnd());
    wait_win(4);
    check("window start", win[4], 1'b1);
    check("drive", drive, 6'h3f);
    check_all(1024, 6'h00);
    $display("test random duty finished");
    div_sel = 12'h1b4;
    check_all(4096, 6'h00);
    $display("test divider finished");
    div_sel = 12'haaa;
    interp = 5'h1f;
    for (int c = 0; c < 6; c++)
      wr_chan(c, 8'h00, 1'b1, IDUTY[c]);
    check_all(8192, 6'h1f);
    $display("test interpolation finished");
    interp = 5'h00;
    shared_sel = 6'h20;
    gdu = 8'h1f;
    for (int c = 0; c < 6; c++)
      wr_chan(c, 8'h00, 1'b1, SDUTY[c]);
    inc_write(1'b1, 10'h393);
    check_all(1024, 6'h00);
    inc_write(1'b0, 10'h3ff);
    check_all(1024, 6'h00);
    $display("test increment finished");
    gating = 8'he4;
    shared_sel = 6'h00;
    gdu = 8'h3f;
    for (int v = 0; v < 2; v++)
    begin
      mcu.pin_level = v ? 4'hf : 4'h0;
      tick(20);
      for (int c = 0; c < 6; c++)
        check("drive", drive[c], on_exp(c));
    end
    check_all(1024, 6'h00);
    $display("test gating finished");
    fail_mode = 1'b1;
    mcu.pin_level = 4'h5;
    tick(12);
    mcu.glitch(1);
    for (int i = 0; i < 10; i++)
    begin
      tick(1);
      check("fail lamp", lamp, 6'h05);
    end
    fail_win = 4'h1;
    wait_win(0);
    check("fail window", win, 5'h01);
    mcu.pin_level = 4'ha;
    tick(12);
    check("fail lamp", lamp, 6'h0a);
    fail_win = 4'h0;
    fail_mode = 1'b0;
    clk_fail = 1'b1;
    tick(6);
    for (int c = 0; c < 6; c++)
      check("clock fail lamp", lamp[c], on_exp(c));
    clk_fail = 1'b0;
    $display("test fail finished");
    gating = 8'h00;
    wr_chan(0, 8'h00, 1'b1, 8'h7f);
    wr_chan(1, 8'h02, 1'b1, 8'h7f);
    tick(1100);
    sync_bit = 1'b1;
    init2_wr = 1'b1;
    tick(1);
    init2_wr = 1'b0;
    sync_bit = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      tick(i ? 300 : 3);
      check("synced lamp", lamp[1:0], 2'b01);
    end
    wr_chan(0, 8'h00, 1'b1, 8'h00);
    tick(3);
    check("deferred duty", lamp[0], 1'b1);
    wr_chan(0, 8'h00, 1'b0, 8'h00);
    tick(3);
    check("turn off", lamp[0], 1'b0);
    wr_chan(1, 8'h02, 1'b1, 8'hff);
    tick(3);
    check("full duty", lamp[1], 1'b1);
    $display("test sync finished");
    finish_test();
  end
endmodule
